// ---- verilog/smst_pkg.sv ----
// Package with register map, field layout and timing constants for the safety self-test block
package smst_pkg;
  localparam int unsigned NUM_SW  = 5;
  localparam int unsigned NUM_LDO = 2;
  localparam int unsigned NUM_RAIL = NUM_SW + NUM_LDO;

  // Register byte offsets (word index times four)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_IRQ      = 8'h08;
  localparam logic [7:0] OFS_SW_OV    = 8'h0c;
  localparam logic [7:0] OFS_LDO_OV   = 8'h10;
  localparam logic [7:0] OFS_SW_UV    = 8'h14;
  localparam logic [7:0] OFS_LDO_UV   = 8'h18;
  localparam logic [7:0] OFS_ID       = 8'h1c;

  // Control register fields
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_BYPASS_BIT = 1;
  localparam int unsigned CTRL_MASK_BIT   = 2;
  localparam int unsigned CTRL_SECEN_BIT  = 3;
  // Status register fields
  localparam int unsigned ST_RANGE_BIT    = 0;
  localparam int unsigned ST_BUSY_BIT     = 1;
  localparam int unsigned ST_BLANK_BIT    = 2;
  localparam int unsigned ST_BLOCK_BIT    = 3;
  localparam int unsigned ST_SHUT_BIT     = 4;
  localparam int unsigned ST_DONE_BIT     = 5;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Block identification, value arbitrary
  localparam logic [31:0] BLOCK_ID   = 32'h0000_5a31;

  // Mismatch band in percent
  localparam logic [7:0] BAND_LO_PCT = 8'h04;
  localparam logic [7:0] BAND_HI_PCT = 8'h0c;

  // Timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned BLANK_MAX_US   = 200;
  localparam int unsigned BLANK_MAX_CYC  = BLANK_MAX_US * CLK_MHZ;
  localparam int unsigned SETTLE_NS      = 500;
  localparam int unsigned SETTLE_CYC     = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SMST_PH_OV_HI,
    SMST_PH_OV_LO,
    SMST_PH_UV_LO,
    SMST_PH_UV_HI
  } smst_phase_t;
endpackage : smst_pkg

// ---- verilog/smst_ref_mon.sv ----
// Reference comparison: range status and critical mismatch detection
`timescale 1ns/1ps
module smst_ref_mon (
  input  wire logic       clk_i,         // Clock
  input  wire logic       rst_i,         // Sync reset
  input  wire logic [7:0] ref_diff_pct_i, // Reference mismatch, percent
  output logic            out_of_range_o, // Range status
  output logic            critical_o     // Mismatch within critical band
);
  logic range_reg;
  logic crit_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      range_reg <= 1'b0;
      crit_reg  <= 1'b0;
    end else begin
      range_reg <= (ref_diff_pct_i >= smst_pkg::BAND_LO_PCT);
      crit_reg  <= (ref_diff_pct_i >= smst_pkg::BAND_LO_PCT) &&
                   (ref_diff_pct_i <= smst_pkg::BAND_HI_PCT);
    end
  end

  assign out_of_range_o = range_reg;
  assign critical_o     = crit_reg;
endmodule : smst_ref_mon

// ---- verilog/smst_seq.sv ----
// Comparator self-test sequencer: walks every rail, checks each comparator toggles
`timescale 1ns/1ps
module smst_seq (
  input  wire logic                           clk_i,      // Clock
  input  wire logic                           rst_i,      // Sync reset
  input  wire logic                           start_i,    // Start pulse
  input  wire logic [smst_pkg::NUM_RAIL-1:0]  ov_cmp_i,   // Overvoltage comparator outputs
  input  wire logic [smst_pkg::NUM_RAIL-1:0]  uv_cmp_i,   // Undervoltage comparator outputs
  output logic      [smst_pkg::NUM_RAIL-1:0]  force_ov_o, // Force rail into OV
  output logic      [smst_pkg::NUM_RAIL-1:0]  force_uv_o, // Force rail into UV
  output logic                                busy_o,     // Test running
  output logic                                done_o,     // One-cycle end pulse
  output logic      [smst_pkg::NUM_RAIL-1:0]  ov_fail_o,  // OV failures, valid at done
  output logic      [smst_pkg::NUM_RAIL-1:0]  uv_fail_o   // UV failures, valid at done
);
  localparam int unsigned RW = $clog2(smst_pkg::NUM_RAIL);
  localparam int unsigned CW = $clog2(smst_pkg::SETTLE_CYC + 1);
  localparam logic [CW-1:0] SETTLE = CW'(smst_pkg::SETTLE_CYC);
  localparam logic [RW-1:0] LAST_RAIL = RW'(smst_pkg::NUM_RAIL - 1);

  logic                          busy_reg;
  logic                          done_reg;
  logic [RW-1:0]                 rail_reg;
  logic [CW-1:0]                 cnt_reg;
  smst_pkg::smst_phase_t         phase_reg;
  logic [smst_pkg::NUM_RAIL-1:0] ov_acc_reg;
  logic [smst_pkg::NUM_RAIL-1:0] uv_acc_reg;
  logic                          step_end;
  logic                          cmp_now;
  logic                          cmp_want;

  assign step_end = (cnt_reg == SETTLE);
  assign cmp_now  = (phase_reg == smst_pkg::SMST_PH_OV_HI ||
                     phase_reg == smst_pkg::SMST_PH_OV_LO) ? ov_cmp_i[rail_reg]
                                                           : uv_cmp_i[rail_reg];
  assign cmp_want = (phase_reg == smst_pkg::SMST_PH_OV_HI ||
                     phase_reg == smst_pkg::SMST_PH_UV_LO);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rail_reg <= '0;
      cnt_reg  <= '0;
      phase_reg <= smst_pkg::SMST_PH_OV_HI;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        if (start_i) begin
          busy_reg  <= 1'b1;
          rail_reg  <= '0;
          cnt_reg   <= '0;
          phase_reg <= smst_pkg::SMST_PH_OV_HI;
        end
      end else if (!step_end) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else begin
        cnt_reg <= '0;
        unique case (phase_reg)
          smst_pkg::SMST_PH_OV_HI: phase_reg <= smst_pkg::SMST_PH_OV_LO;
          smst_pkg::SMST_PH_OV_LO: phase_reg <= smst_pkg::SMST_PH_UV_LO;
          smst_pkg::SMST_PH_UV_LO: phase_reg <= smst_pkg::SMST_PH_UV_HI;
          smst_pkg::SMST_PH_UV_HI: begin
            phase_reg <= smst_pkg::SMST_PH_OV_HI;
            if (rail_reg == LAST_RAIL) begin
              busy_reg <= 1'b0;
              done_reg <= 1'b1;
            end else begin
              rail_reg <= rail_reg + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // Failure accumulation: any phase where the comparator does not follow the stimulus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_acc_reg <= '0;
      uv_acc_reg <= '0;
    end else if (!busy_reg && start_i) begin
      ov_acc_reg <= '0;
      uv_acc_reg <= '0;
    end else if (busy_reg && step_end && (cmp_now != cmp_want)) begin
      if (phase_reg == smst_pkg::SMST_PH_OV_HI || phase_reg == smst_pkg::SMST_PH_OV_LO) begin
        ov_acc_reg[rail_reg] <= 1'b1;
      end else begin
        uv_acc_reg[rail_reg] <= 1'b1;
      end
    end
  end

  // Only the rail under test is stimulated, one comparator at a time
  genvar g;
  generate
    for (g = 0; g < smst_pkg::NUM_RAIL; g++) begin : g_force
      assign force_ov_o[g] = busy_reg && (rail_reg == RW'(g)) &&
                             (phase_reg == smst_pkg::SMST_PH_OV_HI);
      assign force_uv_o[g] = busy_reg && (rail_reg == RW'(g)) &&
                             (phase_reg == smst_pkg::SMST_PH_UV_LO);
    end
  endgenerate

  assign busy_o    = busy_reg;
  assign done_o    = done_reg;
  assign ov_fail_o = ov_acc_reg;
  assign uv_fail_o = uv_acc_reg;
endmodule : smst_seq

// ---- verilog/smst_top.sv ----
// Safety monitor self-test controller with Avalon-MM register slave
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module smst_top (
  input  wire logic                          clk_i,            // Clock, 100 MHz
  input  wire logic                          rst_i,            // Sync reset, active high
  input  wire logic [7:0]                    avs_address,      // Byte address
  input  wire logic                          avs_read,         // Read strobe
  input  wire logic                          avs_write,        // Write strobe
  input  wire logic [31:0]                   avs_writedata,    // Write data
  input  wire logic [3:0]                    avs_byteenable,   // Byte enables
  output logic      [31:0]                   avs_readdata,     // Read data
  output logic                               avs_waitrequest,  // Wait request
  input  wire logic                          secure_write_i,   // Current write is secure
  input  wire logic                          safety_grade_i,   // Safety-grade variant
  input  wire logic                          powerup_req_i,    // Start power-up
  input  wire logic                          system_on_i,      // System in on state
  input  wire logic [7:0]                    ref_diff_pct_i,   // Reference mismatch percent
  input  wire logic [smst_pkg::NUM_RAIL-1:0] ov_cmp_i,         // OV comparator outputs
  input  wire logic [smst_pkg::NUM_RAIL-1:0] uv_cmp_i,         // UV comparator outputs
  output logic      [smst_pkg::NUM_RAIL-1:0] force_ov_o,       // OV test stimulus
  output logic      [smst_pkg::NUM_RAIL-1:0] force_uv_o,       // UV test stimulus
  output logic                               fault_blank_o,    // OV/UV reporting blanked
  output logic                               regulator_block_o, // Block regulator start
  output logic                               power_stage_off_o, // Shut power stages
  output logic                               powerup_go_o,     // Continue power-up
  output logic                               bandgap_irq_o     // Reference fault interrupt
);
  localparam int unsigned BW = $clog2(smst_pkg::BLANK_MAX_CYC + 1);
  localparam logic [BW-1:0] BLANK_MAX = BW'(smst_pkg::BLANK_MAX_CYC);

  logic                          run_reg;
  logic                          bypass_reg;
  logic                          mask_reg;
  logic                          secen_reg;
  logic                          irq_flag_reg;
  logic                          block_reg;
  logic                          shut_reg;
  logic                          go_reg;
  logic                          ondemand_reg;
  logic                          startup_reg;
  logic                          done_seen_reg;
  logic [BW-1:0]                 blank_cnt_reg;
  logic [smst_pkg::NUM_RAIL-1:0] res_ov_reg;
  logic [smst_pkg::NUM_RAIL-1:0] res_uv_reg;
  logic [31:0]                   rdata_reg;
  logic                          rvalid_reg;
  logic                          wr_ok;
  logic                          wr_sec;
  logic                          out_of_range;
  logic                          critical;
  logic                          seq_start;
  logic                          seq_busy;
  logic                          seq_done;
  logic [smst_pkg::NUM_RAIL-1:0] seq_ov_fail;
  logic [smst_pkg::NUM_RAIL-1:0] seq_uv_fail;
  logic                          ref_fail_evt;
  logic                          run_wr;
  logic                          irq_clr;
  logic                          flag_clr;
  logic                          su_trig;

  smst_ref_mon u_ref_mon (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ref_diff_pct_i (ref_diff_pct_i),
    .out_of_range_o (out_of_range),
    .critical_o     (critical)
  );

  smst_seq u_seq (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .start_i    (seq_start),
    .ov_cmp_i   (ov_cmp_i),
    .uv_cmp_i   (uv_cmp_i),
    .force_ov_o (force_ov_o),
    .force_uv_o (force_uv_o),
    .busy_o     (seq_busy),
    .done_o     (seq_done),
    .ov_fail_o  (seq_ov_fail),
    .uv_fail_o  (seq_uv_fail)
  );

  // Bus: writes complete in one cycle, reads in two
  assign avs_waitrequest = avs_read && !rvalid_reg;
  assign wr_ok  = avs_write && avs_byteenable[0];
  assign wr_sec = wr_ok && (!secen_reg || secure_write_i);

  assign run_wr   = wr_sec && (avs_address == smst_pkg::OFS_CTRL) &&
                    avs_writedata[smst_pkg::CTRL_RUN_BIT];
  assign irq_clr  = wr_ok && (avs_address == smst_pkg::OFS_IRQ) && avs_writedata[0];
  assign flag_clr = wr_sec && (avs_address == smst_pkg::OFS_SW_OV ||
                    avs_address == smst_pkg::OFS_LDO_OV ||
                    avs_address == smst_pkg::OFS_SW_UV ||
                    avs_address == smst_pkg::OFS_LDO_UV);

  // Start-up test once per power-up request; a blocked start waits for the request to drop
  assign su_trig   = powerup_req_i && !startup_reg && !go_reg && !block_reg;
  assign seq_start = !seq_busy && (su_trig || (run_wr && !run_reg));

  assign ref_fail_evt = out_of_range && system_on_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bypass_reg <= smst_pkg::CTRL_RESET[smst_pkg::CTRL_BYPASS_BIT];
      mask_reg   <= smst_pkg::CTRL_RESET[smst_pkg::CTRL_MASK_BIT];
      secen_reg  <= smst_pkg::CTRL_RESET[smst_pkg::CTRL_SECEN_BIT];
    end else if (wr_sec && avs_address == smst_pkg::OFS_CTRL) begin
      bypass_reg <= avs_writedata[smst_pkg::CTRL_BYPASS_BIT];
      mask_reg   <= avs_writedata[smst_pkg::CTRL_MASK_BIT];
      secen_reg  <= avs_writedata[smst_pkg::CTRL_SECEN_BIT];
    end
  end

  // Run request bit: set by write when idle, self-clears at test end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_reg      <= 1'b0;
      ondemand_reg <= 1'b0;
    end else if (seq_start && !su_trig) begin
      run_reg      <= 1'b1;
      ondemand_reg <= 1'b1;
    end else if (seq_done) begin
      run_reg      <= 1'b0;
      ondemand_reg <= 1'b0;
    end
  end

  // Blanking window for on-demand tests, hard-limited in length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_cnt_reg <= '0;
    end else if (ondemand_reg && seq_busy && blank_cnt_reg != BLANK_MAX) begin
      blank_cnt_reg <= blank_cnt_reg + 1'b1;
    end else if (!ondemand_reg) begin
      blank_cnt_reg <= '0;
    end
  end
  assign fault_blank_o = ondemand_reg && seq_busy && (blank_cnt_reg != BLANK_MAX);

  // Result flags: all groups loaded together at test end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_ov_reg <= '0;
      res_uv_reg <= '0;
    end else if (seq_done) begin
      res_ov_reg <= seq_ov_fail;
      res_uv_reg <= seq_uv_fail;
    end else if (flag_clr) begin
      unique case (avs_address)
        smst_pkg::OFS_SW_OV:
          res_ov_reg[smst_pkg::NUM_SW-1:0] <= res_ov_reg[smst_pkg::NUM_SW-1:0] &
                                              ~avs_writedata[smst_pkg::NUM_SW-1:0];
        smst_pkg::OFS_LDO_OV:
          res_ov_reg[smst_pkg::NUM_RAIL-1:smst_pkg::NUM_SW] <=
            res_ov_reg[smst_pkg::NUM_RAIL-1:smst_pkg::NUM_SW] &
            ~avs_writedata[smst_pkg::NUM_LDO-1:0];
        smst_pkg::OFS_SW_UV:
          res_uv_reg[smst_pkg::NUM_SW-1:0] <= res_uv_reg[smst_pkg::NUM_SW-1:0] &
                                              ~avs_writedata[smst_pkg::NUM_SW-1:0];
        default:
          res_uv_reg[smst_pkg::NUM_RAIL-1:smst_pkg::NUM_SW] <=
            res_uv_reg[smst_pkg::NUM_RAIL-1:smst_pkg::NUM_SW] &
            ~avs_writedata[smst_pkg::NUM_LDO-1:0];
      endcase
    end
  end

  // Start-up sequence: test, then either go or stay blocked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      startup_reg   <= 1'b0;
      go_reg        <= 1'b0;
      block_reg     <= 1'b0;
      done_seen_reg <= 1'b0;
    end else begin
      if (seq_start && su_trig) begin
        startup_reg   <= 1'b1;
        done_seen_reg <= 1'b0;
      end
      if (startup_reg && critical) begin
        block_reg <= 1'b1;
      end
      if (startup_reg && seq_done) begin
        startup_reg   <= 1'b0;
        done_seen_reg <= 1'b1;
        if (critical || block_reg ||
            (safety_grade_i && out_of_range)) begin
          block_reg <= 1'b1;
        end else begin
          go_reg <= 1'b1;
        end
      end
      if (!powerup_req_i) begin
        go_reg    <= 1'b0;
        block_reg <= 1'b0;
      end
    end
  end

  // System-on drift reaction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shut_reg <= 1'b0;
    end else if (!system_on_i) begin
      shut_reg <= 1'b0;
    end else if (ref_fail_evt && !bypass_reg) begin
      shut_reg <= 1'b1;
    end
  end

  // Sticky interrupt flag; a new event wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_reg <= 1'b0;
    end else if (ref_fail_evt) begin
      irq_flag_reg <= 1'b1;
    end else if (irq_clr) begin
      irq_flag_reg <= 1'b0;
    end
  end

  assign bandgap_irq_o     = irq_flag_reg && !mask_reg;
  assign regulator_block_o = block_reg || (critical && !go_reg);
  assign power_stage_off_o = shut_reg;
  assign powerup_go_o      = go_reg;

  // Read path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= avs_read && !rvalid_reg;
      if (avs_read && !rvalid_reg) begin
        unique case (avs_address)
          smst_pkg::OFS_CTRL:   rdata_reg <= {28'h0, secen_reg, mask_reg, bypass_reg, run_reg};
          smst_pkg::OFS_STATUS: rdata_reg <= {26'h0, done_seen_reg, shut_reg, block_reg,
                                              fault_blank_o, seq_busy, out_of_range};
          smst_pkg::OFS_IRQ:    rdata_reg <= {31'h0, irq_flag_reg};
          smst_pkg::OFS_SW_OV:  rdata_reg <= {27'h0, res_ov_reg[smst_pkg::NUM_SW-1:0]};
          smst_pkg::OFS_LDO_OV: rdata_reg <= {30'h0,
                                              res_ov_reg[smst_pkg::NUM_RAIL-1:smst_pkg::NUM_SW]};
          smst_pkg::OFS_SW_UV:  rdata_reg <= {27'h0, res_uv_reg[smst_pkg::NUM_SW-1:0]};
          smst_pkg::OFS_LDO_UV: rdata_reg <= {30'h0,
                                              res_uv_reg[smst_pkg::NUM_RAIL-1:smst_pkg::NUM_SW]};
          smst_pkg::OFS_ID:     rdata_reg <= smst_pkg::BLOCK_ID;
          default:              rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_readdata = rdata_reg;
endmodule : smst_top

// ---- dv/smst_properties.sv ----
// Port-level checks for the safety self-test controller
`timescale 1ns/1ps
module smst_properties (
  input wire logic                          clk_i,             // Clock
  input wire logic                          rst_i,             // Sync reset
  input wire logic [7:0]                    avs_address,       // Byte address
  input wire logic                          avs_read,          // Read strobe
  input wire logic                          avs_write,         // Write strobe
  input wire logic [31:0]                   avs_readdata,      // Read data
  input wire logic                          avs_waitrequest,   // Wait request
  input wire logic                          system_on_i,       // System on
  input wire logic [7:0]                    ref_diff_pct_i,    // Mismatch percent
  input wire logic [smst_pkg::NUM_RAIL-1:0] force_ov_o,        // OV stimulus
  input wire logic [smst_pkg::NUM_RAIL-1:0] force_uv_o,        // UV stimulus
  input wire logic                          fault_blank_o,     // Blanking
  input wire logic                          regulator_block_o, // Start blocked
  input wire logic                          power_stage_off_o, // Shutdown
  input wire logic                          powerup_go_o,      // Power-up go
  input wire logic                          bandgap_irq_o      // Reference interrupt
);
  localparam int BLANK_LIM = 20000;
  int blank_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !fault_blank_o) blank_cnt <= 0;
    else blank_cnt <= blank_cnt + 1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  read_answer_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read not answered next cycle");
  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 8'h1c
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  blank_limit_a: assert property (blank_cnt < BLANK_LIM)
    else $error("blanking too long");
  one_rail_a: assert property ($onehot0({force_ov_o, force_uv_o}))
    else $error("more than one comparator forced");
  stim_hold_a: assert property ($rose(|force_uv_o) |=> $stable(force_uv_o)[*8])
    else $error("UV stimulus not held");
  crit_block_a: assert property ((ref_diff_pct_i >= 8'h04 && ref_diff_pct_i <= 8'h0c
    && !powerup_go_o)[*2] |-> regulator_block_o) else $error("critical band not blocking");
  go_unblocked_a: assert property ($rose(powerup_go_o) |-> !$past(regulator_block_o))
    else $error("power-up while blocked");
  shut_when_on_a: assert property ($rose(power_stage_off_o) |-> $past(system_on_i))
    else $error("shutdown while off");
  blank_cause_a: assert property ($rose(fault_blank_o)
    |-> $past(avs_write) || $past(avs_write, 2)) else $error("blanking without request");
  cover property ($rose(fault_blank_o));
  cover property ($rose(power_stage_off_o));
  cover property ($rose(bandgap_irq_o));
endmodule : smst_properties

bind smst_top smst_properties smst_properties_inst (.clk_i, .rst_i, .avs_address, .avs_read,
  .avs_write, .avs_readdata, .avs_waitrequest, .system_on_i, .ref_diff_pct_i, .force_ov_o,
  .force_uv_o, .fault_blank_o, .regulator_block_o, .power_stage_off_o, .powerup_go_o,
  .bandgap_irq_o);

// ---- dv/smst_cmp_model.sv ----
// Rail comparators with injectable dead or stuck faults and optional lag
`timescale 1ns/1ps
module smst_cmp_model (
  input  wire logic       clk_i,      // Clock
  input  wire logic       slow_i,     // Answer one cycle late
  input  wire logic [6:0] force_ov_i, // OV stimulus
  input  wire logic [6:0] force_uv_i, // UV stimulus
  input  wire logic [6:0] dead_ov_i,  // OV never toggles
  input  wire logic [6:0] dead_uv_i,  // UV never toggles
  input  wire logic [6:0] stuck_ov_i, // OV stuck high
  input  wire logic [6:0] stuck_uv_i, // UV stuck high
  output logic      [6:0] ov_cmp_o,   // OV comparator
  output logic      [6:0] uv_cmp_o    // UV comparator
);
  logic [6:0] ov_now, uv_now, ov_q, uv_q;
  assign ov_now = (force_ov_i & ~dead_ov_i) | stuck_ov_i;
  assign uv_now = (force_uv_i & ~dead_uv_i) | stuck_uv_i;
  always_ff @(posedge clk_i) begin
    ov_q <= ov_now;
    uv_q <= uv_now;
  end
  assign ov_cmp_o = slow_i ? ov_q : ov_now;
  assign uv_cmp_o = slow_i ? uv_q : uv_now;
endmodule : smst_cmp_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the safety self-test controller
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic        clk_i = 0, rst_i = 1, avs_read = 0, avs_write = 0, slow = 0;
  logic        sec = 0, grade = 0, pwr = 0, son = 0;
  logic [7:0]  addr = 8'h00, diff = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic        wait_o, blank, blk, shut, go, irq;
  logic [6:0]  ovc, uvc, fov, fuv, eo, eu;
  logic [6:0]  dov = 0, duv = 0, sov = 0, suv = 0;
  logic [7:0]  dt [7] = '{8'h00, 8'h03, 8'h0d, 8'h28, 8'h04, 8'h08, 8'h0c};
  int          err_count = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  smst_top smst_top_inst (.clk_i, .rst_i, .avs_address(addr), .avs_read, .avs_write,
    .avs_writedata(wdata), .avs_byteenable(4'hf), .avs_readdata(rdata),
    .avs_waitrequest(wait_o), .secure_write_i(sec), .safety_grade_i(grade),
    .powerup_req_i(pwr), .system_on_i(son), .ref_diff_pct_i(diff), .ov_cmp_i(ovc),
    .uv_cmp_i(uvc), .force_ov_o(fov), .force_uv_o(fuv), .fault_blank_o(blank),
    .regulator_block_o(blk), .power_stage_off_o(shut), .powerup_go_o(go), .bandgap_irq_o(irq));
  smst_cmp_model smst_cmp_model_inst (.clk_i, .slow_i(slow), .force_ov_i(fov), .force_uv_i(fuv),
    .dead_ov_i(dov), .dead_uv_i(duv), .stuck_ov_i(sov), .stuck_uv_i(suv), .ov_cmp_o(ovc),
    .uv_cmp_o(uvc));
  task automatic end_sim();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic s);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    sec <= s;
    avs_write <= 1'b1;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    avs_read <= 1'b1;
    do @(posedge clk_i); while (wait_o !== 1'b0);
    v = rdata;
    avs_read <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d);
    `CHK(d, e)
  endtask : rc
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    pwr <= 1'b0;
    son <= 1'b0;
    diff <= 8'h00;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask : do_reset
  task automatic run_test();
    slow <= ~slow;
    dov <= 7'($urandom) | 7'h01;
    duv <= 7'($urandom);
    sov <= 7'($urandom) & 7'($urandom);
    suv <= 7'($urandom) & 7'($urandom);
    wr(8'h00, 32'h1, 1'b0);
    eo = dov | sov;
    eu = duv | suv;
    @(posedge clk_i);
    #1 `CHK(blank, 1'b1)
    wr(8'h00, 32'h1, 1'b0);
    do rd(8'h00, d); while (d[0] !== 1'b0);
    `CHK(blank, 1'b0)
    rc(8'h0c, {27'h0, eo[4:0]});
    rc(8'h10, {30'h0, eo[6:5]});
    rc(8'h14, {27'h0, eu[4:0]});
    rc(8'h18, {30'h0, eu[6:5]});
  endtask : run_test
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(37127));
    do_reset();
    rc(8'h00, 32'h0);
    rc(8'h20, 32'h0);
    foreach (dt[i]) begin
      diff <= dt[i];
      repeat (3) @(posedge clk_i);
      rd(8'h04, d);
      `CHK(d[0], dt[i] >= 8'h04)
      `CHK(blk, dt[i] >= 8'h04 && dt[i] <= 8'h0c)
    end
    do_reset();
    pwr <= 1'b1;
    while (go !== 1'b1) @(posedge clk_i);
    for (int a = 12; a <= 24; a += 4) rc(8'(a), 32'h0);
    repeat (2) run_test();
    wr(8'h00, 32'h8, 1'b1);
    wr(8'h0c, 32'h1f, 1'b0);
    rc(8'h0c, {27'h0, eo[4:0]});
    wr(8'h0c, 32'h1f, 1'b1);
    rc(8'h0c, 32'h0);
    wr(8'h00, 32'h9, 1'b0);
    repeat (3) @(posedge clk_i);
    `CHK(blank, 1'b0)
    do_reset();
    son <= 1'b1;
    wr(8'h00, 32'h2, 1'b0);
    diff <= 8'h08;
    repeat (3) @(posedge clk_i);
    #1 `CHK(shut, 1'b0)
    `CHK(irq, 1'b1)
    wr(8'h00, 32'h6, 1'b0);
    #1 `CHK(irq, 1'b0)
    wr(8'h00, 32'h0, 1'b0);
    repeat (3) @(posedge clk_i);
    #1 `CHK(shut, 1'b1)
    rc(8'h08, 32'h1);
    son <= 1'b0;
    wr(8'h08, 32'h1, 1'b0);
    rc(8'h08, 32'h0);
    do_reset();
    grade <= 1'b1;
    wr(8'h00, 32'h2, 1'b0);
    diff <= 8'h28;
    pwr <= 1'b1;
    repeat (1500) @(posedge clk_i);
    `CHK(go, 1'b0)
    `CHK(blk, 1'b1)
    end_sim();
  end
endmodule : tb_top
